// >>> rtl/olrc_pkg.sv
// constants and types shared by the on/off, limiter and ramp control block
package olrc_pkg;

  // ==========================================================================
  // widths
  localparam int DATA_W = 16;
  localparam int ADDR_W = 5;

  // ==========================================================================
  // register offsets (word index on the plain register port)
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_CMD = 5'h01;
  localparam logic [4:0] ADDR_HYST_HEAT = 5'h02;
  localparam logic [4:0] ADDR_HYST_COOL = 5'h03;
  localparam logic [4:0] ADDR_DEAD_BAND = 5'h04;
  localparam logic [4:0] ADDR_MV_UPPER = 5'h05;
  localparam logic [4:0] ADDR_MV_LOWER = 5'h06;
  localparam logic [4:0] ADDR_MV_RATE = 5'h07;
  localparam logic [4:0] ADDR_SP_UPPER = 5'h08;
  localparam logic [4:0] ADDR_SP_LOWER = 5'h09;
  localparam logic [4:0] ADDR_SETPOINT = 5'h0a;
  localparam logic [4:0] ADDR_RAMP_AMOUNT = 5'h0b;
  localparam logic [4:0] ADDR_RAMP_BASE = 5'h0c;
  localparam logic [4:0] ADDR_INPUT_CFG = 5'h0d;
  localparam logic [4:0] ADDR_SCALE_HI = 5'h0e;
  localparam logic [4:0] ADDR_SCALE_LO = 5'h0f;
  localparam logic [4:0] ADDR_STATUS = 5'h10;
  localparam logic [4:0] ADDR_RAMP_SP = 5'h11;
  localparam logic [4:0] ADDR_MV_OUT = 5'h12;
  localparam logic [4:0] ADDR_PV = 5'h13;

  // ==========================================================================
  // control register fields
  localparam int CTRL_ONOFF = 0;
  localparam int CTRL_HEAT_COOL = 1;
  localparam int CTRL_DIRECT = 2;
  localparam int CTRL_POS_PROP = 3;
  localparam int CTRL_RUN = 4;
  localparam int CTRL_MANUAL = 5;
  localparam int CTRL_SELF_TUNE = 6;
  localparam int CTRL_ERROR = 7;
  localparam int CTRL_W = 8;

  // command register fields (write only, self clearing)
  localparam int CMD_AT_START = 0;
  localparam int CMD_AT_STOP = 1;

  // status register fields
  localparam int STAT_HEAT = 0;
  localparam int STAT_COOL = 1;
  localparam int STAT_RAMPING = 2;
  localparam int STAT_AT_HELD = 3;
  localparam int STAT_AT_RUN = 4;

  // ==========================================================================
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h10;
  localparam logic [15:0] HYST_RST = 16'h0008;
  localparam logic [15:0] DEAD_BAND_RST = 16'h0000;
  localparam logic [15:0] MV_UPPER_RST = 16'h03e8;
  localparam logic [15:0] MV_LOWER_RST = 16'hfc18;
  localparam logic [15:0] MV_RATE_RST = 16'h0000;
  localparam logic [15:0] SCALE_HI_RST = 16'h0578;
  localparam logic [15:0] SCALE_LO_RST = 16'hff38;
  localparam logic [15:0] SETPOINT_RST = 16'h0000;
  localparam logic [15:0] RAMP_AMOUNT_RST = 16'h0000;
  localparam logic [1:0] RAMP_BASE_RST = 2'h0;
  localparam logic [7:0] INPUT_CFG_RST = 8'h00;

  // ==========================================================================
  // ramp time base codes and their length in seconds
  localparam logic [1:0] BASE_SECOND = 2'h0;
  localparam logic [1:0] BASE_MINUTE = 2'h1;
  localparam logic [1:0] BASE_HOUR = 2'h2;
  localparam logic [11:0] SECS_PER_MINUTE = 12'h03c;
  localparam logic [11:0] SECS_PER_HOUR = 12'he10;

  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_PERIOD_NS = 1_000_000_000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {AT_IDLE, AT_HELD, AT_RUN} olrc_at_type;

endpackage

// >>> rtl/olrc_top.sv
// on/off switching, output clamp, rate limiter, setpoint limiter and ramp
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps

module olrc_top #(
  parameter int unsigned TICK_CYCLES = olrc_pkg::TICK_CYCLES
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [4:0] addr_i,
  input wire logic [15:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rd_data_o,
  input wire logic signed [15:0] process_value_i,
  input wire logic signed [15:0] mv_computed_i,
  output logic signed [15:0] manipulated_variable_o,
  output logic signed [15:0] control_setpoint_o,
  output logic heat_on_o,
  output logic cool_on_o,
  output logic auto_tuning_o
);

  // ==========================================================================
  // helpers
  function automatic logic signed [15:0] clamp(input logic signed [15:0] x,
      input logic signed [15:0] lo, input logic signed [15:0] hi);
    logic signed [15:0] r;
    r = x;
    if (x > hi) begin
      r = hi;
    end else if (x < lo) begin
      r = lo;
    end
    return r;
  endfunction

  // difference is taken at 18 bits so a full-scale swing cannot wrap
  function automatic logic signed [15:0] step_toward(
      input logic signed [15:0] cur, input logic signed [15:0] tgt,
      input logic [15:0] step);
    logic signed [17:0] diff;
    logic signed [17:0] st;
    logic signed [17:0] r;
    diff = 18'(tgt) - 18'(cur);
    st = 18'(signed'({1'b0, step}));
    r = 18'(tgt);
    if (diff > st) begin
      r = 18'(cur) + st;
    end else if (diff < -st) begin
      r = 18'(cur) - st;
    end
    return r[15:0];
  endfunction

  function automatic logic [11:0] base_secs(input logic [1:0] base);
    logic [11:0] r;
    r = 12'h001;
    if (base == olrc_pkg::BASE_MINUTE) begin
      r = olrc_pkg::SECS_PER_MINUTE;
    end else if (base == olrc_pkg::BASE_HOUR) begin
      r = olrc_pkg::SECS_PER_HOUR;
    end
    return r;
  endfunction

  // ==========================================================================
  // registers
  logic [7:0] ctrl;
  logic [15:0] hyst_heat;
  logic [15:0] hyst_cool;
  logic [15:0] dead_band;
  logic signed [15:0] mv_upper;
  logic signed [15:0] mv_lower;
  logic [15:0] mv_rate;
  logic signed [15:0] sp_upper;
  logic signed [15:0] sp_lower;
  logic signed [15:0] setpoint;
  logic [15:0] ramp_step_amount;
  logic [1:0] ramp_time_base;
  logic [7:0] input_cfg;
  logic signed [15:0] scale_hi;
  logic signed [15:0] scale_lo;
  logic range_changed;
  logic limits_changed;
  logic signed [15:0] ramp_sp;
  logic ramp_restart;
  logic [27:0] tick_cnt;
  logic sec_tick;
  logic [11:0] base_cnt;
  logic ramp_tick;
  olrc_pkg::olrc_at_type at_state;

  wire logic wr_ctrl = wr_i && addr_i == olrc_pkg::ADDR_CTRL;
  wire logic wr_cmd = wr_i && addr_i == olrc_pkg::ADDR_CMD;
  wire logic onoff = ctrl[olrc_pkg::CTRL_ONOFF];
  wire logic heat_cool = ctrl[olrc_pkg::CTRL_HEAT_COOL];
  wire logic pos_prop = ctrl[olrc_pkg::CTRL_POS_PROP];
  wire logic run = ctrl[olrc_pkg::CTRL_RUN];
  wire logic manual = ctrl[olrc_pkg::CTRL_MANUAL];
  wire logic self_tune = ctrl[olrc_pkg::CTRL_SELF_TUNE];
  wire logic fault = ctrl[olrc_pkg::CTRL_ERROR];
  wire logic ramp_en = ramp_step_amount != 16'h0000;
  wire logic ramp_live = ramp_en && run && !fault;
  wire logic ramping = ramp_live && ramp_sp != setpoint;
  wire logic signed [15:0] sp_eff = ramp_live ? ramp_sp : setpoint;

  // ==========================================================================
  // control register: on/off never coexists with position-proportional
  logic [7:0] next_ctrl;
  always_comb begin
    next_ctrl = wr_data_i[7:0];
    if (next_ctrl[olrc_pkg::CTRL_POS_PROP]) begin
      next_ctrl[olrc_pkg::CTRL_ONOFF] = 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ctrl <= olrc_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl <= next_ctrl;
    end
  end

  // ==========================================================================
  // tuning and limit parameters
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      hyst_heat <= olrc_pkg::HYST_RST;
      hyst_cool <= olrc_pkg::HYST_RST;
      dead_band <= olrc_pkg::DEAD_BAND_RST;
      mv_upper <= olrc_pkg::MV_UPPER_RST;
      mv_lower <= olrc_pkg::MV_LOWER_RST;
      mv_rate <= olrc_pkg::MV_RATE_RST;
      ramp_step_amount <= olrc_pkg::RAMP_AMOUNT_RST;
      ramp_time_base <= olrc_pkg::RAMP_BASE_RST;
    end else if (wr_i) begin
      unique case (addr_i)
        olrc_pkg::ADDR_HYST_HEAT: hyst_heat <= wr_data_i;
        olrc_pkg::ADDR_HYST_COOL: begin
          if (heat_cool) begin
            hyst_cool <= wr_data_i;
          end
        end
        olrc_pkg::ADDR_DEAD_BAND: dead_band <= wr_data_i;
        olrc_pkg::ADDR_MV_UPPER: mv_upper <= wr_data_i;
        olrc_pkg::ADDR_MV_LOWER: mv_lower <= wr_data_i;
        olrc_pkg::ADDR_MV_RATE: mv_rate <= wr_data_i;
        olrc_pkg::ADDR_RAMP_AMOUNT: ramp_step_amount <= wr_data_i;
        olrc_pkg::ADDR_RAMP_BASE: ramp_time_base <= wr_data_i[1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // input range and setpoint limits
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      input_cfg <= olrc_pkg::INPUT_CFG_RST;
      scale_hi <= olrc_pkg::SCALE_HI_RST;
      scale_lo <= olrc_pkg::SCALE_LO_RST;
      range_changed <= 1'b0;
    end else begin
      range_changed <= 1'b0;
      if (wr_i && addr_i == olrc_pkg::ADDR_INPUT_CFG) begin
        input_cfg <= wr_data_i[7:0];
        range_changed <= wr_data_i[7:0] != input_cfg;
      end
      if (wr_i && addr_i == olrc_pkg::ADDR_SCALE_HI) begin
        scale_hi <= wr_data_i;
        range_changed <= wr_data_i != scale_hi;
      end
      if (wr_i && addr_i == olrc_pkg::ADDR_SCALE_LO) begin
        scale_lo <= wr_data_i;
        range_changed <= wr_data_i != scale_lo;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      sp_upper <= olrc_pkg::SCALE_HI_RST;
      sp_lower <= olrc_pkg::SCALE_LO_RST;
      limits_changed <= 1'b0;
    end else begin
      limits_changed <= 1'b0;
      if (range_changed) begin
        sp_upper <= scale_hi;
        sp_lower <= scale_lo;
        limits_changed <= 1'b1;
      end else if (wr_i && addr_i == olrc_pkg::ADDR_SP_UPPER) begin
        sp_upper <= wr_data_i;
        limits_changed <= 1'b1;
      end else if (wr_i && addr_i == olrc_pkg::ADDR_SP_LOWER) begin
        sp_lower <= wr_data_i;
        limits_changed <= 1'b1;
      end
    end
  end

  // a setpoint write in the reclamp cycle is clamped too, so neither is lost
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      setpoint <= olrc_pkg::SETPOINT_RST;
    end else if (wr_i && addr_i == olrc_pkg::ADDR_SETPOINT) begin
      setpoint <= clamp(wr_data_i, sp_lower, sp_upper);
    end else if (limits_changed) begin
      setpoint <= clamp(setpoint, sp_lower, sp_upper);
    end
  end

  // ==========================================================================
  // one-second tick and ramp time base
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      tick_cnt <= 28'h0000000;
      sec_tick <= 1'b0;
    end else if (tick_cnt == 28'(TICK_CYCLES - 1)) begin
      tick_cnt <= 28'h0000000;
      sec_tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 28'h0000001;
      sec_tick <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i || !ramp_live) begin
      base_cnt <= 12'h000;
      ramp_tick <= 1'b0;
    end else begin
      ramp_tick <= 1'b0;
      if (sec_tick) begin
        if (base_cnt >= base_secs(ramp_time_base) - 12'h001) begin
          base_cnt <= 12'h000;
          ramp_tick <= 1'b1;
        end else begin
          base_cnt <= base_cnt + 12'h001;
        end
      end
    end
  end

  // ==========================================================================
  // setpoint ramp; manual mode does not stop it
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ramp_sp <= olrc_pkg::SETPOINT_RST;
      ramp_restart <= 1'b1;
    end else if (!run || fault || !ramp_en) begin
      ramp_sp <= setpoint;
      ramp_restart <= ramp_restart || !run;
    end else if (ramp_restart) begin
      ramp_sp <= process_value_i;
      ramp_restart <= 1'b0;
    end else if (ramp_tick) begin
      ramp_sp <= step_toward(ramp_sp, setpoint, ramp_step_amount);
    end
  end

  // ==========================================================================
  // auto-tuning request is parked while the ramp is still moving
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      at_state <= olrc_pkg::AT_IDLE;
    end else if (wr_cmd && wr_data_i[olrc_pkg::CMD_AT_STOP]) begin
      at_state <= olrc_pkg::AT_IDLE;
    end else begin
      unique case (at_state)
        olrc_pkg::AT_IDLE: begin
          if (wr_cmd && wr_data_i[olrc_pkg::CMD_AT_START] && !pos_prop) begin
            at_state <= ramping ? olrc_pkg::AT_HELD : olrc_pkg::AT_RUN;
          end
        end
        olrc_pkg::AT_HELD: begin
          if (!ramping) begin
            at_state <= olrc_pkg::AT_RUN;
          end
        end
        olrc_pkg::AT_RUN: ;
      endcase
    end
  end

  // ==========================================================================
  // manipulated variable: clamp then rate limit
  wire logic at_run = at_state == olrc_pkg::AT_RUN;
  wire logic hard_bypass = onoff || self_tune || manual || !run || fault;
  wire logic clamp_on = !hard_bypass && !pos_prop;
  wire logic rate_on = !hard_bypass && !at_run && mv_rate != 16'h0000;
  // signed clamp: heat side positive up to upper, cool negative down to lower
  wire logic signed [15:0] mv_target = clamp_on ?
      clamp(mv_computed_i, mv_lower, mv_upper) : mv_computed_i;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      manipulated_variable_o <= 16'h0000;
    end else if (!rate_on) begin
      manipulated_variable_o <= mv_target;
    end else if (sec_tick) begin
      manipulated_variable_o <= step_toward(manipulated_variable_o,
          mv_target, mv_rate);
    end
  end

  // ==========================================================================
  // on/off switching against the effective setpoint
  logic signed [17:0] dev;
  logic signed [17:0] half_db;
  logic signed [17:0] hh;
  logic signed [17:0] hc;
  always_comb begin
    dev = 18'(process_value_i) - 18'(sp_eff);
    // sign kept so a negative dead band turns into an overlap band
    half_db = heat_cool ? 18'(signed'(dead_band)) >>> 1 : 18'sh00000;
    hh = 18'(signed'({1'b0, hyst_heat}));
    hc = 18'(signed'({1'b0, hyst_cool}));
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i || !onoff || !run || fault) begin
      heat_on_o <= 1'b0;
      cool_on_o <= 1'b0;
    end else if (heat_cool) begin
      if (dev <= -half_db - hh) begin
        heat_on_o <= 1'b1;
      end else if (dev >= -half_db) begin
        heat_on_o <= 1'b0;
      end
      if (dev >= half_db + hc) begin
        cool_on_o <= 1'b1;
      end else if (dev <= half_db) begin
        cool_on_o <= 1'b0;
      end
    end else if (ctrl[olrc_pkg::CTRL_DIRECT]) begin
      cool_on_o <= 1'b0;
      if (dev >= hh) begin
        heat_on_o <= 1'b1;
      end else if (dev <= 18'sh00000) begin
        heat_on_o <= 1'b0;
      end
    end else begin
      cool_on_o <= 1'b0;
      if (dev <= -hh) begin
        heat_on_o <= 1'b1;
      end else if (dev >= 18'sh00000) begin
        heat_on_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      control_setpoint_o <= olrc_pkg::SETPOINT_RST;
      auto_tuning_o <= 1'b0;
    end else begin
      control_setpoint_o <= sp_eff;
      auto_tuning_o <= at_run;
    end
  end

  // ==========================================================================
  // read port: data valid the cycle after the strobe, zero otherwise
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    unique case (addr_i)
      olrc_pkg::ADDR_CTRL: rd_mux = {8'h00, ctrl};
      olrc_pkg::ADDR_HYST_HEAT: rd_mux = hyst_heat;
      olrc_pkg::ADDR_HYST_COOL: rd_mux = hyst_cool;
      olrc_pkg::ADDR_DEAD_BAND: rd_mux = dead_band;
      olrc_pkg::ADDR_MV_UPPER: rd_mux = mv_upper;
      olrc_pkg::ADDR_MV_LOWER: rd_mux = mv_lower;
      olrc_pkg::ADDR_MV_RATE: rd_mux = mv_rate;
      olrc_pkg::ADDR_SP_UPPER: rd_mux = sp_upper;
      olrc_pkg::ADDR_SP_LOWER: rd_mux = sp_lower;
      olrc_pkg::ADDR_SETPOINT: rd_mux = setpoint;
      olrc_pkg::ADDR_RAMP_AMOUNT: rd_mux = ramp_step_amount;
      olrc_pkg::ADDR_RAMP_BASE: rd_mux = {14'h0000, ramp_time_base};
      olrc_pkg::ADDR_INPUT_CFG: rd_mux = {8'h00, input_cfg};
      olrc_pkg::ADDR_SCALE_HI: rd_mux = scale_hi;
      olrc_pkg::ADDR_SCALE_LO: rd_mux = scale_lo;
      olrc_pkg::ADDR_STATUS: begin
        rd_mux[olrc_pkg::STAT_HEAT] = heat_on_o;
        rd_mux[olrc_pkg::STAT_COOL] = cool_on_o;
        rd_mux[olrc_pkg::STAT_RAMPING] = ramping;
        rd_mux[olrc_pkg::STAT_AT_HELD] = at_state == olrc_pkg::AT_HELD;
        rd_mux[olrc_pkg::STAT_AT_RUN] = at_run;
      end
      olrc_pkg::ADDR_RAMP_SP: rd_mux = sp_eff;
      olrc_pkg::ADDR_MV_OUT: rd_mux = manipulated_variable_o;
      olrc_pkg::ADDR_PV: rd_mux = process_value_i;
      default: rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i || !rd_i) begin
      rd_data_o <= 16'h0000;
    end else begin
      rd_data_o <= rd_mux;
    end
  end

endmodule

// >>> sim/olrc_assertions.sv
// port checker for the on/off, limiter and ramp control block
`timescale 1ns/1ps
module olrc_checker (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [4:0] addr_i,
  input wire logic [15:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rd_data_o,
  input wire logic signed [15:0] mv_computed_i,
  input wire logic signed [15:0] manipulated_variable_o,
  input wire logic signed [15:0] control_setpoint_o,
  input wire logic heat_on_o,
  input wire logic cool_on_o,
  input wire logic auto_tuning_o
);
  // ==========================================================================
  // shadow of the settings; scale low and input config are not followed
  logic [7:0] ctl;
  logic signed [15:0] mvh, mvl, rate, sph, spl, sch, ramp, mvp;
  logic signed [16:0] dmv;
  logic [2:0] quiet;
  logic byp;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  assign byp = ctl[0] | ctl[5] | ctl[6] | !ctl[4] | ctl[7];
  assign dmv = 17'(manipulated_variable_o) - 17'(mvp);
  always_ff @(posedge mclk_i) mvp <= manipulated_variable_o;
  always_ff @(posedge mclk_i) begin
    if (reset_i || wr_i) quiet <= 3'h0;
    else if (quiet != 3'h5) quiet <= quiet + 3'h1;
  end
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ctl <= olrc_pkg::CTRL_RST;
      {mvh, mvl, rate} <= {16'h03e8, 16'hfc18, 16'h0000};
      {sph, spl, sch, ramp} <= {16'h0578, 16'hff38, 16'h0578, 16'h0000};
    end else if (wr_i) begin
      case (addr_i)
        5'h00: ctl <= {wr_data_i[7:1], wr_data_i[0] & !wr_data_i[3]};
        5'h05: mvh <= wr_data_i;
        5'h06: mvl <= wr_data_i;
        5'h07: rate <= wr_data_i;
        5'h08: sph <= wr_data_i;
        5'h09: spl <= wr_data_i;
        5'h0b: ramp <= wr_data_i;
        5'h0e: if (wr_data_i != sch) begin
          sch <= wr_data_i;
          {sph, spl} <= {wr_data_i, olrc_pkg::SCALE_LO_RST};
        end
        default: ;
      endcase
    end
  end
  // ==========================================================================
  // properties
  rd_idle_a: assert property (!$past(rd_i) |-> rd_data_o == 16'h0000)
    else $error("read data outside its slot");
  ctl_read_a: assert property (
    $past(rd_i && addr_i == 5'h00) |-> rd_data_o == {8'h00, $past(ctl)})
    else $error("control register read back wrong");
  mv_bypass_a: assert property (
    $past(byp) && !$past(reset_i) |->
    manipulated_variable_o == $past(mv_computed_i))
    else $error("bypassed output differs from computed value");
  mv_upper_a: assert property (
    !$past(byp | ctl[3] | wr_i | reset_i) && rate == 0 |->
    manipulated_variable_o <= mvh)
    else $error("output above upper limit");
  mv_lower_a: assert property (
    !$past(byp | ctl[3] | wr_i | reset_i) && rate == 0 |->
    manipulated_variable_o >= mvl)
    else $error("output below lower limit");
  mv_rate_a: assert property (
    !$past(byp | wr_i | reset_i | auto_tuning_o) && !auto_tuning_o &&
    rate != 0 |-> dmv <= rate && -dmv <= rate)
    else $error("output moved faster than the rate setting");
  onoff_idle_a: assert property (
    !$past(ctl[0] & ctl[4] & !ctl[7]) |-> !heat_on_o && !cool_on_o)
    else $error("switching output on outside on/off operation");
  sp_range_a: assert property (
    quiet == 3'h5 && (ramp == 0 || !ctl[4] || ctl[7]) |->
    control_setpoint_o <= sph && control_setpoint_o >= spl)
    else $error("setpoint in force outside its limits");
  heat_c: cover property ($rose(heat_on_o));
  cool_c: cover property ($rose(cool_on_o));
  tune_c: cover property ($rose(auto_tuning_o));
endmodule
bind olrc_top olrc_checker olrc_checker_i (.mclk_i, .reset_i, .addr_i,
  .wr_data_i, .wr_i, .rd_i, .rd_data_o, .mv_computed_i,
  .manipulated_variable_o, .control_setpoint_o, .heat_on_o, .cool_on_o,
  .auto_tuning_o);

// >>> sim/olrc_plant.sv
// partner model: process sensor and upstream algorithm feeding the block
`timescale 1ns/1ps
module olrc_plant (
  input wire logic mclk_i,
  input wire logic signed [15:0] pv_set_i,
  input wire logic signed [15:0] mv_set_i,
  output logic signed [15:0] process_value_o = 16'sh0000,
  output logic signed [15:0] mv_computed_o = 16'sh0000
);
  // ==========================================================================
  // sampled once a clock like a converter, so stimulus arrives a cycle late
  always_ff @(posedge mclk_i) begin
    process_value_o <= pv_set_i;
    mv_computed_o <= mv_set_i;
  end
endmodule

// >>> sim/test_olrc_top.sv
// self-checking bench for the on/off, limiter and ramp control block
`timescale 1ns/1ps
module test_olrc_top;
  localparam int TICK = 20;
  localparam logic [4:0] RA[8] = '{5'h00, 5'h02, 5'h03, 5'h05, 5'h06,
    5'h08, 5'h09, 5'h0e};
  localparam logic [15:0] RV[8] = '{16'h0010, 16'h0008, 16'h0008,
    16'h03e8, 16'hfc18, 16'h0578, 16'hff38, 16'h0578};
  localparam logic [15:0] PVT[9] = '{16'hfff8, 16'hfffc, 16'h0000,
    16'h0009, 16'h0006, 16'h0005, 16'hfff3, 16'hfffa, 16'hfffb};
  localparam logic [15:0] STT[9] = '{16'h1, 16'h1, 16'h0, 16'h2, 16'h2,
    16'h0, 16'h1, 16'h1, 16'h0};
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [4:0] addr_i = 5'h00;
  logic [15:0] wr_data_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic rd_seen = 1'b0;
  logic [15:0] rd_data_o, v;
  logic signed [15:0] process_value_i, mv_computed_i, manipulated_variable_o;
  logic signed [15:0] control_setpoint_o;
  logic signed [15:0] pv_set = 16'sh0000;
  logic signed [15:0] mv_set = 16'sh0000;
  logic heat_on_o, cool_on_o, auto_tuning_o;
  logic [15:0] exp_q[$];
  int bad_count = 0;
  int checks = 0;
  olrc_top #(.TICK_CYCLES(TICK)) olrc_top_i (.mclk_i, .reset_i, .addr_i,
    .wr_data_i, .wr_i, .rd_i, .rd_data_o, .process_value_i, .mv_computed_i,
    .manipulated_variable_o, .control_setpoint_o, .heat_on_o, .cool_on_o,
    .auto_tuning_o);
  olrc_plant olrc_plant_i (.mclk_i, .pv_set_i(pv_set), .mv_set_i(mv_set),
    .process_value_o(process_value_i), .mv_computed_o(mv_computed_i));
  initial forever #2 mclk_i = ~mclk_i;
  // ==========================================================================
  // bus tasks and comparison
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checks++;
    if (seen !== want) begin
      bad_count++;
      $display("unexpected at %0t: seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic ok_if(input logic c);
    check({15'h0000, c}, 16'h0001);
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wr_data_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    exp_q.push_back(e);
    @(posedge mclk_i);
    rd_i <= 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask
  task automatic done(input string s);
    repeat (3) @(posedge mclk_i);
    $display("test %s done", s);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // read data is judged at the falling edge, where it has settled
  always @(posedge mclk_i) rd_seen <= rd_i;
  always @(negedge mclk_i) if (rd_seen) check(rd_data_o, exp_q.pop_front());
  initial begin
    repeat (40 * TICK + 20000) @(posedge mclk_i);
    bad_count++;
    tally_and_finish;
  end
  // ==========================================================================
  // scenarios
  initial begin
    void'($urandom(23314));
    repeat (16) @(posedge mclk_i);
    reset_i <= 1'b0;
    foreach (RA[i]) rd(RA[i], RV[i]);
    rd(5'h1f, 16'h0000);
    done("reset values");
    wr(5'h00, 16'h0019);
    rd(5'h00, 16'h0018);
    wr(5'h00, 16'h0010);
    wr(5'h08, 16'h0064);
    wr(5'h09, 16'hff9c);
    wr(5'h0a, 16'h01f4);
    rd(5'h0a, 16'h0064);
    wr(5'h08, 16'h0032);
    rd(5'h0a, 16'h0032);
    rd(5'h11, 16'h0032);
    wr(5'h0e, 16'h0200);
    rd(5'h08, 16'h0200);
    rd(5'h09, 16'hff38);
    done("setpoint limits");
    mv_set <= 16'sh07d0;
    settle(3);
    rd(5'h12, 16'h03e8);
    mv_set <= 16'shf830;
    settle(3);
    rd(5'h12, 16'hfc18);
    wr(5'h00, 16'h0030);
    for (int i = 0; i < 4; i++) begin
      v = 16'($urandom);
      mv_set <= v;
      settle(3);
      rd(5'h12, v);
    end
    mv_set <= 16'sh0000;
    wr(5'h07, 16'h0005);
    wr(5'h00, 16'h0010);
    mv_set <= 16'sh0064;
    settle(10 * TICK);
    ok_if(manipulated_variable_o >= 45 && manipulated_variable_o <= 55);
    wr(5'h01, 16'h0001);
    mv_set <= 16'sh012c;
    settle(3);
    rd(5'h12, 16'h012c);
    wr(5'h01, 16'h0002);
    wr(5'h07, 16'h0000);
    wr(5'h00, 16'h0018);
    mv_set <= 16'sh07d0;
    settle(3);
    rd(5'h12, 16'h07d0);
    done("output conditioning");
    wr(5'h0a, 16'h0000);
    wr(5'h00, 16'h0011);
    wr(5'h03, 16'h0003);
    rd(5'h03, 16'h0008);
    for (int i = 0; i < 9; i++) begin
      if (i == 3) begin
        wr(5'h00, 16'h0013);
        wr(5'h04, 16'h000a);
        wr(5'h03, 16'h0004);
      end
      pv_set <= PVT[i];
      settle(3);
      check({14'h0000, cool_on_o, heat_on_o}, STT[i]);
      rd(5'h10, STT[i]);
    end
    done("on off");
    pv_set <= 16'sh0000;
    wr(5'h00, 16'h0000);
    wr(5'h0b, 16'h0002);
    wr(5'h00, 16'h0010);
    wr(5'h0a, 16'h0014);
    wr(5'h01, 16'h0001);
    rd(5'h10, 16'h000c);
    settle(3 * TICK);
    ok_if(control_setpoint_o > 0 && control_setpoint_o < 20);
    settle(12 * TICK);
    rd(5'h11, 16'h0014);
    rd(5'h10, 16'h0010);
    ok_if(auto_tuning_o);
    wr(5'h01, 16'h0002);
    wr(5'h0a, 16'hfff6);
    settle(2 * TICK);
    ok_if(control_setpoint_o > -10 && control_setpoint_o < 20);
    wr(5'h00, 16'h0030);
    settle(16 * TICK);
    rd(5'h11, 16'hfff6);
    wr(5'h0a, 16'h0014);
    wr(5'h00, 16'h0000);
    settle(3);
    rd(5'h11, 16'h0014);
    pv_set <= 16'sh0005;
    wr(5'h00, 16'h0010);
    settle(3);
    ok_if(control_setpoint_o >= 5 && control_setpoint_o <= 7);
    done("ramp");
    tally_and_finish;
  end
endmodule
